// ==== design/fap_flash_protect.v ====
`timescale 1ns/1ps
`include "fap_map.vh"

// Function
// - single and dual bank modes; in dual bank mode reads go to one bank while the other is busy.
// - three readout protection levels, level 0 restricts nothing.
// - level 1 blocks all memory access while debug is attached or alt boot is set.
// - level 2 kills debug and alt boot for good and can never be lowered.
// - program or erase inside the write protected area is rejected.
// - the execute-only area admits only processor instruction fetches.
// - an option bit chooses whether the execute-only area is wiped on level 1 to 0.
// - after reset the securable area is open like the rest of main memory.
// - once secured, every access to the securable area errors until reset.
// - ecc corrects single bit errors and flags double bit errors.
// - the address of an ecc failure is kept in a readable register.
// - 1 Kbyte otp of 128 double words in the first bank, write once; the erase code is refused, the unknown op code still erases.
module fap_flash_protect (
   input wire clk,
   input wire sys_rst,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   output wire irq,
   input wire reqValid,
   output wire reqReady,
   input wire [1:0] reqMaster,
   input wire [1:0] reqOp,
   input wire reqOtp,
   input wire [`FAP_AW-1:0] reqAddr,
   input wire [31:0] reqWdata,
   output reg rspValid,
   output reg rspError,
   output reg [31:0] rspRdata,
   output reg flashRead,
   output reg flashProgram,
   output reg flashErase,
   output reg flashOtp,
   output reg [`FAP_AW-1:0] flashAddr,
   output reg [`FAP_CW-1:0] flashWdata,
   input wire [`FAP_CW-1:0] flashRdata,
   input wire flashRdValid,
   input wire [1:0] flashBusy,
   output reg flashMassErase,
   output reg flashKeepExec,
   output reg optLevelWr,
   output reg [1:0] optLevelNew,
   input wire [1:0] optProtLevel,
   input wire optDualBank,
   input wire [`FAP_AW-1:0] optWprotStart,
   input wire [`FAP_AW-1:0] optWprotEnd,
   input wire [`FAP_AW-1:0] optExecStart,
   input wire [`FAP_AW-1:0] optExecEnd,
   input wire optEraseExec,
   input wire [`FAP_AW-1:0] optSecEnd,
   input wire dbgPresentPin,
   input wire bootAltPin,
   output wire debugDisable,
   output wire bootRestrict
);
   localparam ST_IDLE = 1'b0;
   localparam ST_READ = 1'b1;

   reg state;
   reg [1:0] protLevel;
   reg levelLoaded;
   reg secured;
   reg [`FAP_ST_W-1:0] status;
   reg [`FAP_ST_W-1:0] mask;
   reg [`FAP_AW-1:0] eccAddr;
   reg [`FAP_OTP_DWORDS-1:0] otpUsed;
   reg dbgMeta;
   reg dbgSync;
   reg bootMeta;
   reg bootSync;
   reg dpWrite;
   reg [7:0] dpAddr;
   reg [`FAP_ST_W-1:0] next_status;
   reg [31:0] readMux;
   wire [`FAP_SYN_W:0] encCheck;
   wire [`FAP_DW-1:0] decData;
   wire decSingle;
   wire decDouble;

   // pins from outside the clock domain, two flops before use
   always @(posedge clk) begin
      if (sys_rst) begin
         dbgMeta <= 1'b0;
         dbgSync <= 1'b0;
         bootMeta <= 1'b0;
         bootSync <= 1'b0;
      end else begin
         dbgMeta <= dbgPresentPin;
         dbgSync <= dbgMeta;
         bootMeta <= bootAltPin;
         bootSync <= bootMeta;
      end
   end

   fap_ecc u_ecc (
      .encData(reqWdata),
      .encCheck(encCheck),
      .decWord(flashRdata),
      .decData(decData),
      .decSingle(decSingle),
      .decDouble(decDouble)
   );

   // request classification
   wire isRead = (reqOp == `FAP_OP_READ);
   wire inMain = ~reqOtp;
   wire bankSel = optDualBank & reqAddr[`FAP_BANK_BIT] & inMain;
   // dual bank stalls only on the addressed bank; single bank on any work
   wire stall = optDualBank ? flashBusy[bankSel] : |flashBusy;
   wire denyLevel = ((protLevel == `FAP_LVL1) & (dbgSync | bootSync))
      | ((protLevel == `FAP_LVL2) & (reqMaster == `FAP_M_DEBUG));
   wire denySec = secured & inMain & (reqAddr < optSecEnd);
   wire execHit = inMain & (optExecStart <= optExecEnd)
      & (reqAddr >= optExecStart) & (reqAddr <= optExecEnd);
   wire denyExec = execHit & ((reqMaster != `FAP_M_INSTR) | ~isRead);
   wire denyWprot = inMain & ~isRead & (optWprotStart <= optWprotEnd)
      & (reqAddr >= optWprotStart) & (reqAddr <= optWprotEnd);
   // otp: beyond 1 Kbyte, the erase code, or a second program of a double word
   wire otpRange = |reqAddr[`FAP_AW-1:`FAP_OTP_TOP_LO];
   wire denyOtp = reqOtp & (otpRange | (reqOp == `FAP_OP_ERASE)
      | ((reqOp == `FAP_OP_PROG)
      & otpUsed[reqAddr[`FAP_OTP_DW_HI:`FAP_OTP_DW_LO]]));
   wire denyAny = denyLevel | denySec | denyExec | denyWprot | denyOtp;
   // a request that will be refused need not wait for a busy bank
   assign reqReady = (state == ST_IDLE) & levelLoaded & (denyAny | ~stall);
   wire take = reqValid & reqReady;
   wire rdDone = (state == ST_READ) & flashRdValid;

   // one cause per refused request, level checks first
   wire [`FAP_ST_W-1:0] events;
   assign events[`FAP_ST_CORR] = rdDone & decSingle;
   assign events[`FAP_ST_DOUBLE] = rdDone & decDouble;
   assign events[`FAP_ST_LEVEL] = take & denyLevel;
   assign events[`FAP_ST_SECURE] = take & ~denyLevel & denySec;
   assign events[`FAP_ST_EXEC] = take & ~denyLevel & ~denySec & denyExec;
   assign events[`FAP_ST_WPROT] = take & ~denyLevel & ~denySec & ~denyExec
      & denyWprot;
   assign events[`FAP_ST_OTP] = take & ~denyLevel & ~denySec & ~denyExec
      & ~denyWprot & denyOtp;

   // access sequencer toward the array
   always @(posedge clk) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         rspValid <= 1'b0;
         rspError <= 1'b0;
         rspRdata <= 32'h0000_0000;
         flashRead <= 1'b0;
         flashProgram <= 1'b0;
         flashErase <= 1'b0;
         flashOtp <= 1'b0;
         flashAddr <= {`FAP_AW{1'b0}};
         flashWdata <= {`FAP_CW{1'b0}};
         eccAddr <= {`FAP_AW{1'b0}};
         // write-once flags are volatile; the array itself must refuse
         // reprogramming across resets
         otpUsed <= {`FAP_OTP_DWORDS{1'b0}};
      end else begin
         rspValid <= 1'b0;
         flashRead <= 1'b0;
         flashProgram <= 1'b0;
         flashErase <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (take) begin
                  flashAddr <= reqAddr;
                  flashOtp <= reqOtp;
                  flashWdata <= {encCheck, reqWdata};
                  if (denyAny) begin
                     // no strobe reaches the array
                     rspValid <= 1'b1;
                     rspError <= 1'b1;
                  end else if (isRead) begin
                     flashRead <= 1'b1;
                     state <= ST_READ;
                  end else if (reqOp == `FAP_OP_PROG) begin
                     flashProgram <= 1'b1;
                     rspValid <= 1'b1;
                     rspError <= 1'b0;
                     if (reqOtp)
                        otpUsed[reqAddr[`FAP_OTP_DW_HI:`FAP_OTP_DW_LO]]
                           <= 1'b1;
                  end else begin
                     // erase codes other than the known ones erase too
                     flashErase <= 1'b1;
                     rspValid <= 1'b1;
                     rspError <= 1'b0;
                  end
               end
            end
            ST_READ: begin
               if (flashRdValid) begin
                  rspValid <= 1'b1;
                  rspRdata <= decData;
                  rspError <= decDouble;
                  if (decSingle | decDouble)
                     eccAddr <= flashAddr;
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // sticky status; an event in the clearing read cycle survives
   always @* begin
      next_status = status | events;
      if (hsel & htrans[1] & hready & ~hwrite
         & (haddr[7:0] == `FAP_OFS_STATUS))
         next_status = events;
   end

   // register read mux, sampled in the address phase
   always @* begin
      case (haddr[7:0])
         `FAP_OFS_STATUS: readMux = {25'h0, status};
         `FAP_OFS_MASK: readMux = {25'h0, mask};
         `FAP_OFS_CTRL: readMux = {31'h0, secured};
         `FAP_OFS_LEVEL: readMux = {30'h0, protLevel};
         `FAP_OFS_ECCADDR: readMux = {13'h0, eccAddr};
         `FAP_OFS_INFO: readMux = {29'h0, secured, optDualBank,
            debugDisable};
         default: readMux = 32'h0000_0000;
      endcase
   end

   // ahb-lite slave: zero wait, always okay, word registers only
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign irq = |(status & mask);

   always @(posedge clk) begin
      if (sys_rst) begin
         dpWrite <= 1'b0;
         dpAddr <= 8'h00;
         hrdata <= 32'h0000_0000;
         status <= `FAP_ST_RESET;
         mask <= `FAP_ST_RESET;
         secured <= 1'b0;
         protLevel <= `FAP_LVL1;
         levelLoaded <= 1'b0;
         flashMassErase <= 1'b0;
         flashKeepExec <= 1'b0;
         optLevelWr <= 1'b0;
         optLevelNew <= `FAP_LVL0;
      end else begin
         flashMassErase <= 1'b0;
         optLevelWr <= 1'b0;
         status <= next_status;
         dpWrite <= hsel & htrans[1] & hready & hwrite;
         if (hsel & htrans[1] & hready) begin
            dpAddr <= haddr[7:0];
            if (~hwrite)
               hrdata <= readMux;
         end
         // level strap caught once after release; bad codes act as level 1
         if (~levelLoaded) begin
            levelLoaded <= 1'b1;
            protLevel <= (optProtLevel == `FAP_LVL_BAD) ? `FAP_LVL1
               : optProtLevel;
         end else if (dpWrite) begin
            case (dpAddr)
               `FAP_OFS_MASK: mask <= hwdata[`FAP_ST_W-1:0];
               `FAP_OFS_CTRL: begin
                  if (hwdata[`FAP_CTRL_SECLOCK])
                     secured <= 1'b1;
               end
               `FAP_OFS_LEVEL: begin
                  if (protLevel == `FAP_LVL2) begin
                     // level 2 ignores every request
                     optLevelWr <= 1'b0;
                  end else if ((protLevel == `FAP_LVL1)
                     && (hwdata[1:0] == `FAP_LVL0)) begin
                     // regression wipes the array; exec area by option
                     flashMassErase <= 1'b1;
                     flashKeepExec <= ~optEraseExec;
                     protLevel <= `FAP_LVL0;
                     optLevelWr <= 1'b1;
                     optLevelNew <= `FAP_LVL0;
                  end else if ((hwdata[1:0] > protLevel)
                     && (hwdata[1:0] != `FAP_LVL_BAD)) begin
                     protLevel <= hwdata[1:0];
                     optLevelWr <= 1'b1;
                     optLevelNew <= hwdata[1:0];
                  end
               end
               default: begin
                  mask <= mask;
               end
            endcase
         end
      end
   end

   // level 2 fuses off debug and the alternate boot paths
   assign debugDisable = (protLevel == `FAP_LVL2);
   assign bootRestrict = (protLevel == `FAP_LVL2);

endmodule // fap_flash_protect

// ==== design/fap_map.vh ====
`ifndef FAP_MAP_VH
`define FAP_MAP_VH

// register byte offsets on the AHB-Lite slave
`define FAP_OFS_STATUS 8'h00
`define FAP_OFS_MASK 8'h04
`define FAP_OFS_CTRL 8'h08
`define FAP_OFS_LEVEL 8'h0c
`define FAP_OFS_ECCADDR 8'h10
`define FAP_OFS_INFO 8'h14

// status and mask bit positions
`define FAP_ST_CORR 0
`define FAP_ST_DOUBLE 1
`define FAP_ST_LEVEL 2
`define FAP_ST_WPROT 3
`define FAP_ST_EXEC 4
`define FAP_ST_SECURE 5
`define FAP_ST_OTP 6
`define FAP_ST_W 7
`define FAP_ST_RESET 7'h00

// control and info bits
`define FAP_CTRL_SECLOCK 0
`define FAP_INFO_DBGDIS 0
`define FAP_INFO_DUAL 1
`define FAP_INFO_SECURED 2

// readout protection levels
`define FAP_LVL0 2'h0
`define FAP_LVL1 2'h1
`define FAP_LVL2 2'h2
`define FAP_LVL_BAD 2'h3

// request operations and masters
`define FAP_OP_READ 2'h0
`define FAP_OP_PROG 2'h1
`define FAP_OP_ERASE 2'h2
`define FAP_M_INSTR 2'h0
`define FAP_M_DATA 2'h1
`define FAP_M_DMA 2'h2
`define FAP_M_DEBUG 2'h3

// address layout
`define FAP_AW 19
`define FAP_BANK_BIT 18
`define FAP_OTP_DW_HI 9
`define FAP_OTP_DW_LO 3
`define FAP_OTP_TOP_LO 10
`define FAP_OTP_DWORDS 128

// ecc code word: 32 data bits, 6 hamming bits, 1 overall parity
`define FAP_DW 32
`define FAP_CW 39
`define FAP_CW_LAST 38
`define FAP_SYN_W 6

`endif

// ==== design/fap_ecc.v ====
`timescale 1ns/1ps
`include "fap_map.vh"

module fap_ecc (
   input wire [`FAP_DW-1:0] encData,
   output reg [`FAP_SYN_W:0] encCheck,
   input wire [`FAP_CW-1:0] decWord,
   output reg [`FAP_DW-1:0] decData,
   output reg decSingle,
   output reg decDouble
);
   reg [`FAP_CW_LAST:0] cw;
   reg [`FAP_SYN_W-1:0] esyn;
   reg [`FAP_SYN_W-1:0] syn;
   reg par;
   integer p;
   integer j;
   integer k;
   integer ep;
   integer ej;

   // hamming check bits: xor of positions holding a one
   always @* begin
      esyn = {`FAP_SYN_W{1'b0}};
      ej = 0;
      for (ep = 1; ep <= `FAP_CW_LAST; ep = ep + 1) begin
         if ((ep & (ep - 1)) != 0) begin
            if (encData[ej])
               esyn = esyn ^ ep[`FAP_SYN_W-1:0];
            ej = ej + 1;
         end
      end
      // overall parity makes the whole word even
      encCheck = {(^encData) ^ (^esyn), esyn};
   end

   // rebuild positions, correct one flip, flag two
   always @* begin
      cw = {(`FAP_CW_LAST+1){1'b0}};
      syn = {`FAP_SYN_W{1'b0}};
      decData = {`FAP_DW{1'b0}};
      j = 0;
      k = 0;
      for (p = 1; p <= `FAP_CW_LAST; p = p + 1) begin
         if ((p & (p - 1)) == 0) begin
            cw[p] = decWord[`FAP_DW + k];
            k = k + 1;
         end else begin
            cw[p] = decWord[j];
            j = j + 1;
         end
      end
      for (p = 1; p <= `FAP_CW_LAST; p = p + 1) begin
         if (cw[p])
            syn = syn ^ p[`FAP_SYN_W-1:0];
      end
      par = ^decWord;
      // odd parity with a syndrome past the word means more than one flip
      decSingle = par && (syn <= `FAP_CW_LAST);
      decDouble = (!par && (syn != 0)) || (par && (syn > `FAP_CW_LAST));
      if (decSingle && (syn != 0))
         cw[syn] = ~cw[syn];
      j = 0;
      for (p = 1; p <= `FAP_CW_LAST; p = p + 1) begin
         if ((p & (p - 1)) != 0) begin
            decData[j] = cw[p];
            j = j + 1;
         end
      end
   end
endmodule // fap_ecc

// ==== verif/fap_flash_model.sv ====
`timescale 1ns/1ps
module fap_flash_model (
   input wire clk,
   input wire [2:0] rdLat,
   input wire flashRead,
   input wire flashProgram,
   input wire flashErase,
   input wire flashOtp,
   input wire [18:0] flashAddr,
   input wire [38:0] flashWdata,
   output reg [38:0] flashRdata,
   output reg flashRdValid,
   output wire [1:0] flashBusy
);
   logic [38:0] mem [int];
   integer busy0 = 0;
   integer busy1 = 0;
   integer waitCnt = -1;
   integer rdKey = 0;
   integer key;
   // one busy flag per bank, so the idle bank stays readable
   assign flashBusy = {busy1 != 0, busy0 != 0};
   initial begin
      flashRdValid = 1'b0;
      flashRdata = 39'h0;
   end
   // array timing; read data toggles whenever it is not valid
   always @(posedge clk) begin
      key = {flashOtp, flashAddr[18:2]};
      flashRdValid <= 1'b0;
      flashRdata <= ~flashRdata;
      if (busy0 > 0) busy0 <= busy0 - 1;
      if (busy1 > 0) busy1 <= busy1 - 1;
      if (flashRead) begin
         rdKey <= key;
         waitCnt <= rdLat;
      end else if (waitCnt == 0) begin
         flashRdValid <= 1'b1;
         flashRdata <= mem.exists(rdKey) ? mem[rdKey] : ~flashRdata;
         waitCnt <= -1;
      end else if (waitCnt > 0) begin
         waitCnt <= waitCnt - 1;
      end
      if (flashProgram) mem[key] = flashWdata;
      // otp cells have no erase path at all
      if (flashErase && !flashOtp) mem.delete(key);
      if ((flashProgram || flashErase) && (flashOtp || !flashAddr[18]))
         busy0 <= 12;
      else if (flashProgram || flashErase)
         busy1 <= 12;
   end
endmodule // fap_flash_model

// ==== verif/fap_flash_protect_chk.sv ====
`timescale 1ns/1ps
`include "fap_map.vh"
module fap_flash_protect_chk (
   input wire clk,
   input wire sys_rst,
   input wire reqValid,
   input wire reqReady,
   input wire [1:0] reqMaster,
   input wire [1:0] reqOp,
   input wire rspValid,
   input wire rspError,
   input wire flashRead,
   input wire flashProgram,
   input wire flashErase,
   input wire flashRdValid,
   input wire flashMassErase,
   input wire flashKeepExec,
   input wire optLevelWr,
   input wire [1:0] optLevelNew,
   input wire optEraseExec,
   input wire debugDisable
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // request steps: taken, then answered one cycle later
   sequence takenWr;
      reqValid && reqReady && reqOp != `FAP_OP_READ;
   endsequence
   sequence answerWr;
      rspValid && ((flashProgram || flashErase) != rspError);
   endsequence
   sequence dbgTaken;
      debugDisable && reqValid && reqReady && reqMaster == `FAP_M_DEBUG;
   endsequence
   chk_prog_answer: assert property (takenWr |=> answerWr)
      else $error("write request not answered cleanly");
   chk_refuse_clean: assert property (
      rspValid && rspError |-> !(flashProgram || flashErase || flashRead))
      else $error("refused access reached the array");
   chk_read_busy: assert property (flashRead |-> !reqReady)
      else $error("request taken while a read is open");
   chk_read_answer: assert property (flashRdValid |=> rspValid)
      else $error("read data not answered");
   chk_mass_erase: assert property (flashMassErase |-> optLevelWr
      && optLevelNew == `FAP_LVL0 && flashKeepExec == !optEraseExec)
      else $error("wipe pulse with wrong companions");
   chk_lvl2_sticky: assert property (debugDisable |=> debugDisable)
      else $error("top level dropped");
   chk_lvl2_nowrite: assert property (
      debugDisable && $past(debugDisable) |-> !optLevelWr)
      else $error("level write at top level");
   chk_lvl2_debug: assert property (dbgTaken |=> rspValid && rspError)
      else $error("debug access served at top level");
endmodule // fap_flash_protect_chk
bind fap_flash_protect fap_flash_protect_chk u_chk (.clk, .sys_rst,
   .reqValid, .reqReady, .reqMaster, .reqOp, .rspValid, .rspError,
   .flashRead, .flashProgram, .flashErase, .flashRdValid, .flashMassErase,
   .flashKeepExec, .optLevelWr, .optLevelNew, .optEraseExec, .debugDisable);

// ==== verif/test_flash_access_protection_ecc.sv ====
`timescale 1ns/1ps
`include "fap_map.vh"
module test_flash_access_protection_ecc;
   localparam [1:0] RD = `FAP_OP_READ, PG = `FAP_OP_PROG, ER = `FAP_OP_ERASE;
   localparam [1:0] IN = `FAP_M_INSTR, DA = `FAP_M_DATA, DM = `FAP_M_DMA;
   reg clk, sys_rst, hsel, hwrite, reqValid, reqOtp, optEraseExec;
   reg dbgPresentPin, bootAltPin;
   reg [31:0] haddr, hwdata, reqWdata, rdv;
   reg [18:0] reqAddr, optWprotStart, optWprotEnd, optExecStart, optExecEnd;
   reg [18:0] optSecEnd;
   reg [1:0] htrans, reqMaster, reqOp, optProtLevel;
   reg [2:0] hsize, rdLat;
   wire hreadyout, hresp, irq, reqReady, rspValid, rspError, flashRead;
   wire flashProgram, flashErase, flashOtp, flashRdValid, flashMassErase;
   wire flashKeepExec, optLevelWr, debugDisable, bootRestrict;
   wire [31:0] hrdata, rspRdata;
   wire [18:0] flashAddr;
   wire [38:0] flashWdata, flashRdata;
   wire [1:0] flashBusy, optLevelNew;
   integer n_fail, num_checks, expSt, lvl, secured, nMass, keepSeen, i, b;
   logic [31:0] expMem [int];
   bit otpUsed [128];

   fap_flash_protect uut (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq,
      .reqValid, .reqReady, .reqMaster, .reqOp, .reqOtp, .reqAddr, .reqWdata,
      .rspValid, .rspError, .rspRdata, .flashRead, .flashProgram, .flashErase,
      .flashOtp, .flashAddr, .flashWdata, .flashRdata, .flashRdValid,
      .flashBusy, .flashMassErase, .flashKeepExec, .optLevelWr, .optLevelNew,
      .optProtLevel, .optDualBank(1'b1), .optWprotStart, .optWprotEnd,
      .optExecStart, .optExecEnd, .optEraseExec, .optSecEnd, .dbgPresentPin,
      .bootAltPin, .debugDisable, .bootRestrict);
   fap_flash_model u_flash (.clk, .rdLat, .flashRead, .flashProgram,
      .flashErase, .flashOtp, .flashAddr, .flashWdata, .flashRdata,
      .flashRdValid, .flashBusy);

   task cmp(input [31:0] got, input [31:0] exp, input string s);
      num_checks = num_checks + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("BAD %0t %s got %h exp %h", $time, s, got, exp);
      end
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // single word transfer: address phase, then data phase
   task ahb(input wr, input [7:0] a, input [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rdv = hrdata;
   endtask
   task reg_chk(input [7:0] a, input [31:0] e);
      ahb(1'b0, a, 32'h0);
      cmp(rdv, e, "register");
   endtask
   // status read also clears the expected copy
   task st_chk;
      reg_chk(`FAP_OFS_STATUS, expSt);
      expSt = 0;
   endtask
   // reference decision, highest priority first
   function integer fault(input [1:0] m, input [1:0] op, input o,
         input [18:0] a);
      if ((lvl == 1 && (dbgPresentPin || bootAltPin)) ||
            (lvl == 2 && m == `FAP_M_DEBUG)) return `FAP_ST_LEVEL;
      if (!o && secured && a < optSecEnd) return `FAP_ST_SECURE;
      if (!o && a >= optExecStart && a <= optExecEnd &&
            (m != IN || op != RD)) return `FAP_ST_EXEC;
      if (!o && op != RD && a >= optWprotStart && a <= optWprotEnd)
         return `FAP_ST_WPROT;
      if (o && (op == ER || (op == PG && otpUsed[a[9:3]])))
         return `FAP_ST_OTP;
      return -1;
   endfunction
   // one access; ecc 1 = single flip expected, 2 = double flip
   task acc(input [1:0] m, input [1:0] op, input o, input [18:0] a,
         input [31:0] wd, input integer ecc);
      integer f, k, err, n;
      f = fault(m, op, o, a);
      k = {o, a[18:2]};
      @(posedge clk);
      reqValid <= 1'b1;
      reqMaster <= m;
      reqOp <= op;
      reqOtp <= o;
      reqAddr <= a;
      reqWdata <= wd;
      rdLat <= $urandom % 4;
      do @(negedge clk); while (reqReady !== 1'b1);
      @(posedge clk);
      reqValid <= 1'b0;
      n = 0;
      do begin
         @(negedge clk);
         n = n + 1;
      end while (rspValid !== 1'b1 && n < 40);
      err = (f >= 0 || ecc == 2);
      if (f >= 0) expSt = expSt | (1 << f);
      else if (ecc > 0) expSt = expSt | (1 << (ecc - 1));
      cmp(rspValid, 1, "response");
      cmp(rspError, err, "error flag");
      if (!err && op == RD) cmp(rspRdata, expMem[k], "read data");
      if (!err && op == PG) begin
         expMem[k] = wd;
         if (o) otpUsed[a[9:3]] = 1'b1;
      end
   endtask
   task rst(input [1:0] lv);
      @(posedge clk);
      optProtLevel <= lv;
      sys_rst <= 1'b1;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk);
      lvl = lv;
      secured = 0;
      expSt = 0;
      otpUsed = '{default: 1'b0};
   endtask

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // wipe pulses and their keep flag, seen away from the edge
   always @(negedge clk) if (flashMassErase === 1'b1) begin
      nMass = nMass + 1;
      keepSeen = flashKeepExec;
   end
   // hang guard, more than ten times the expected run
   initial begin
      #400000;
      n_fail = n_fail + 1;
      $display("BAD %0t timeout", $time);
      end_sim;
   end
   initial begin
      {n_fail, num_checks, nMass, keepSeen, expSt, lvl, secured} = 0;
      // reset stands from time zero so no edge sees unknown state
      sys_rst = 1'b1;
      {hsel, hwrite, htrans, haddr, hwdata} = 0;
      {reqValid, reqOtp, reqMaster, reqOp, reqAddr, reqWdata, rdLat} = 0;
      {dbgPresentPin, bootAltPin, optProtLevel} = 0;
      hsize = 3'h2;
      b = $urandom(32'hc15d);
      optEraseExec = $urandom % 2;
      {optWprotStart, optWprotEnd} = {19'h01000, 19'h01fff};
      {optExecStart, optExecEnd, optSecEnd} = {19'h7ffff, 19'h0, 19'h00800};
      rst(2'h0);
      // level 0 programs freely, exec area still inactive
      acc(DA, PG, 0, 19'h03000, $urandom, 0);
      acc(DA, PG, 0, 19'h02000, $urandom, 0);
      acc(DA, PG, 0, 19'h00100, $urandom, 0);
      reg_chk(`FAP_OFS_STATUS, 0);
      reg_chk(`FAP_OFS_MASK, 0);
      reg_chk(8'h18, 0);
      reg_chk(`FAP_OFS_LEVEL, 0);
      // bank 0 read served while bank 1 programs
      acc(DA, PG, 0, 19'h43000, $urandom, 0);
      acc(DA, RD, 0, 19'h03000, 0, 0);
      cmp(flashBusy[1], 1, "other bank busy");
      // one flipped bit corrected, two refused
      b = $urandom % 39;
      u_flash.mem[32'h0c00] = u_flash.mem[32'h0c00] ^ (39'h1 << b);
      acc(DA, RD, 0, 19'h03000, 0, 1);
      reg_chk(`FAP_OFS_ECCADDR, 32'h03000);
      u_flash.mem[32'h0c00] = u_flash.mem[32'h0c00] ^ (39'h1 << b);
      u_flash.mem[32'h10c00] = u_flash.mem[32'h10c00] ^ (39'h3 << (b % 37));
      acc(DM, RD, 0, 19'h43000, 0, 2);
      reg_chk(`FAP_OFS_ECCADDR, 32'h43000);
      // irq follows the mask, then drops on the status read
      cmp(irq, 0, "irq masked");
      ahb(1'b1, `FAP_OFS_MASK, 32'h7f);
      @(negedge clk);
      cmp(irq, 1, "irq raised");
      st_chk;
      @(negedge clk);
      cmp(irq, 0, "irq cleared");
      // write protected range and its edges
      acc(DA, PG, 0, 19'h01000, $urandom, 0);
      acc(DM, ER, 0, 19'h01ffc, 0, 0);
      acc(DA, PG, 0, 19'h00ffc, $urandom, 0);
      // every master and operation against the execute-only area
      @(posedge clk);
      optExecStart <= 19'h02000;
      optExecEnd <= 19'h02fff;
      for (i = 0; i < 12; i = i + 1)
         acc(i % 4, i / 4, 0, 19'h02000, 0, 0);
      st_chk;
      // otp double words are written once, never erased
      acc(DA, PG, 1, 19'h00008, $urandom, 0);
      acc(DA, PG, 1, 19'h0000c, $urandom, 0);
      acc(DA, RD, 1, 19'h00008, 0, 0);
      acc(DA, ER, 1, 19'h00008, 0, 0);
      acc(DA, PG, 1, 19'h003fc, $urandom, 0);
      st_chk;
      // securable area open, then locked until reset
      acc(DA, RD, 0, 19'h00100, 0, 0);
      ahb(1'b1, `FAP_OFS_CTRL, 32'h1);
      secured = 1;
      reg_chk(`FAP_OFS_CTRL, 1);
      acc(IN, RD, 0, 19'h00100, 0, 0);
      acc(DM, PG, 0, 19'h007fc, $urandom, 0);
      acc(DA, PG, 0, 19'h00804, $urandom, 0);
      st_chk;
      // level 1: debugger or alternate boot shuts the memory
      rst(2'h1);
      acc(DA, RD, 0, 19'h00100, 0, 0);
      for (i = 1; i < 4; i = i + 1) begin
         dbgPresentPin <= i[0];
         bootAltPin <= i[1];
         repeat (4) @(posedge clk);
         acc(DA, i == 3 ? PG : RD, 0, 19'h03000, 0, 0);
      end
      dbgPresentPin <= 1'b0;
      bootAltPin <= 1'b0;
      repeat (4) @(posedge clk);
      acc(DA, RD, 0, 19'h03000, 0, 0);
      st_chk;
      // lowering to level 0 asks for a wipe
      ahb(1'b1, `FAP_OFS_LEVEL, 32'h0);
      repeat (2) @(posedge clk);
      cmp(nMass, 1, "wipe count");
      cmp(keepSeen, !optEraseExec, "keep flag");
      // level 2 cannot be lowered and bars the debugger
      rst(2'h2);
      cmp(debugDisable, 1, "debug off");
      cmp(bootRestrict, 1, "boot off");
      ahb(1'b1, `FAP_OFS_LEVEL, 32'h0);
      reg_chk(`FAP_OFS_LEVEL, 2);
      cmp(nMass, 1, "no wipe");
      acc(`FAP_M_DEBUG, RD, 0, 19'h03000, 0, 0);
      acc(DA, RD, 0, 19'h03000, 0, 0);
      reg_chk(`FAP_OFS_INFO, 32'h3);
      st_chk;
      end_sim;
   end
endmodule // test_flash_access_protection_ecc
